// ---- verilog/fdc_glue_defines.svh ----
// Register offsets, field positions, reset values and timing constants
`ifndef FDC_GLUE_DEFINES_SVH
`define FDC_GLUE_DEFINES_SVH

`define OFS_CTRL0          3'h2
`define OFS_STATUS_CTRL1   3'h4
`define OFS_DATA           3'h5
`define OFS_RATE_DIR       3'h7

`define CTRL0_CORE_RUN_BIT 2
`define CTRL0_REQ_EN_BIT   3
`define CTRL0_RESET        8'h00
`define CTRL1_STANDBY_BIT  0
`define CTRL1_AUX_LO_BIT   4
`define CTRL1_AUX_HI_BIT   6
`define CTRL1_RESET        8'h00
`define RATE_RESET         2'h0
`define DIR_DSKCHG_BIT     7
`define STAT_RQM_BIT       7
`define STAT_BUSY_BIT      4
`define STAT_FMREF_BIT     1
`define STAT_BADCMD_BIT    0

`define RATE_CODE_500K     2'h0
`define RATE_CODE_ALT      2'h1
`define RATE_CODE_250K     2'h2
`define RATE_CODE_1M       2'h3

`define REF_CLK_KHZ        16'h9C40
`define CORE_KHZ_8M        16'h1F40
`define CORE_KHZ_4M        16'h0FA0
`define CORE_KHZ_16M       16'h3E80
`define CORE_KHZ_4M8       16'h12C0
`define BIT_KHZ_1M         16'h03E8
`define BIT_KHZ_500K       16'h01F4
`define BIT_KHZ_300K       16'h012C
`define BIT_KHZ_250K       16'h00FA
`define BIT_KHZ_125K       16'h007D

`define OPC_MASK           8'h1F
`define OPC_SPECIFY        8'h03
`define OPC_SENSE_INT      8'h08
`define OPC_SCAN_EQ        8'h11
`define OPC_SCAN_LE        8'h19
`define OPC_SCAN_HE        8'h1D
`define ST0_READY_CHG      2'h3

`define CRC_POLY           16'h1021
`define CRC_INIT           16'hFFFF
`define NUM_DRIVES         4

`endif

// ---- verilog/fdc_glue_pkg.sv ----
// Types shared by the controller glue
package fdc_glue_pkg;

    typedef enum logic [1:0] {
        CMD_IDLE,
        CMD_SPEC_STEP,
        CMD_SPEC_HEAD
    } cmd_state_t;

    typedef struct packed {
        logic [15:0] coreKhz;
        logic [15:0] bitKhz;
        logic        valid;
        logic        fmOk;
    } rate_info_t;

    typedef struct packed {
        logic ackN;
        logic mode;
        logic xtal24;
        logic idsel;
        logic dskChgN;
        logic readyN;
    } pin_set_t;

endpackage : fdc_glue_pkg

// ---- verilog/crc16_unit.sv ----
// Bit-serial CRC generator and checker for recorded fields
`timescale 1ns/10ps
`default_nettype none
`include "fdc_glue_defines.svh"

module crc16_unit (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        init,
    input  wire logic        bitValid,
    input  wire logic        bitIn,
    output logic [15:0]      crc
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    function automatic logic [15:0] crcStep(input logic [15:0] c,
                                            input logic b);
        logic fb;
        fb = c[15] ^ b;
        crcStep = {c[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    endfunction : crcStep

    always_comb begin
        crc_nxt = crc_r;
        if (init) begin
            crc_nxt = `CRC_INIT;
        end else if (bitValid) begin
            crc_nxt = crcStep(crc_r, bitIn);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            crc_r <= `CRC_INIT;
        end else begin
            crc_r <= crc_nxt;
        end
    end

    assign crc = crc_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    crc_shift_a: assert property (!init && bitValid
        && !(crc_r[15] ^ bitIn) |=> crc_r == {$past(crc_r[14:0]), 1'b0})
        else $error("crc shift term wrong");
    crc_feedback_a: assert property (!init && bitValid
        && (crc_r[15] ^ bitIn)
        |=> crc_r == ({$past(crc_r[14:0]), 1'b0} ^ `CRC_POLY))
        else $error("crc feedback term missing");
endmodule : crc16_unit
`default_nettype wire

// ---- verilog/fdc_host_control_glue.sv ----
// Host-side control glue around the embedded disk controller core
//
// Behaviour
// - DMA request drops on a bare acknowledge, with no read or write strobe.
// - Normal rate codes 00/10/11: 8/4/16MHz, 500K/250K/1M; 01 undefined.
// - FM runs at 125Kbps on standard and mini settings, never at 1Mbps.
// - 24MHz clock, mode pin high: 00 500K, 01 300K, 10 250K, 11 undefined.
// - At 300Kbps only MFM recording is offered.
// - After core reset ready flag clears; with drive ready asserted, one poll pass raises four causes.
// - Standby follows only the standby request bit of the second register.
// - The three scan commands are not implemented.
// - Timing setup uses only step interval; head load fields are ignored.
// - Bit D2 of first register holds core in reset; resets to zero.
// - Rate field resets to the standard floppy setting.
// - Auxiliary pins mirror their bits in the second register.
// - CRC uses polynomial x^16 + x^12 + x^5 + 1.
// - First register: digital output; fourth: rate on write, input on read.
// - Output-enable bit low forces DMA and interrupt requests inactive.
`timescale 1ns/10ps
`default_nettype none
`include "fdc_glue_defines.svh"

module fdc_host_control_glue (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [7:0]       regRdData,
    input  wire logic        dma_acknowledge_n,
    input  wire logic        modePin,
    input  wire logic        crystalIs24,
    input  wire logic        idselPin,
    input  wire logic        diskChangeN,
    input  wire logic        driveReadyN,
    input  wire logic        coreDmaReq,
    input  wire logic        coreFmSel,
    input  wire logic        coreBit,
    input  wire logic        coreBitValid,
    input  wire logic        crcInit,
    output logic             coreResetN,
    output logic             coreClkEn,
    output logic             bitRateEn,
    output logic             standbyOut,
    output logic             aux_output_upper,
    output logic             aux_output_lower,
    output logic             request_output_enable,
    output logic             dma_request_out,
    output logic             dmaRequestOe,
    output logic             interrupt_request_out,
    output logic             interruptRequestOe,
    output logic [3:0]       stepInterval,
    output logic             driveReady,
    output logic [15:0]      crcValue
);
    fdc_glue_pkg::pin_set_t   pinMeta_r, pinSync_r, pinRaw;
    fdc_glue_pkg::rate_info_t rateInfo, rateBase;
    fdc_glue_pkg::cmd_state_t cmdState_r, cmdState_nxt;

    logic [7:0]  digital_output_reg_r, digital_output_reg_nxt;
    logic [7:0]  ctrl1_r, ctrl1_nxt;
    logic [1:0]  rateSel_r, rateSel_nxt;
    logic [7:0]  rdData_r, rdData_nxt;
    logic [7:0]  result_r, result_nxt;
    logic [3:0]  step_r, step_nxt;
    logic        badCmd_r, badCmd_nxt;
    logic        dmaReq_r, dmaReq_nxt;
    logic [15:0] coreAcc_r, coreAcc_nxt, bitAcc_r, bitAcc_nxt;
    logic        coreEn_r, coreEn_nxt, bitEn_r, bitEn_nxt;
    logic        readyFlag_r, readyFlag_nxt;
    logic        polling_r, polling_nxt;
    logic [1:0]  pollDrv_r, pollDrv_nxt;
    logic [3:0]  cause_r, cause_nxt;
    logic        coreRun, altMode, wrData, opcSense, fmRefused;

    // Rate lookup used by both clock enables
    function automatic fdc_glue_pkg::rate_info_t rateLookup(
        input logic [1:0] code, input logic alt, input logic fm);
        fdc_glue_pkg::rate_info_t r;
        r = '0;
        unique case (code)
            `RATE_CODE_500K: begin
                r = {`CORE_KHZ_8M, `BIT_KHZ_500K, 1'b1, 1'b1};
            end
            `RATE_CODE_ALT: begin
                if (alt) begin
                    r = {`CORE_KHZ_4M8, `BIT_KHZ_300K, 1'b1, 1'b0};
                end
            end
            `RATE_CODE_250K: begin
                r = {`CORE_KHZ_4M, `BIT_KHZ_250K, 1'b1, 1'b1};
            end
            `RATE_CODE_1M: begin
                if (!alt) begin
                    r = {`CORE_KHZ_16M, `BIT_KHZ_1M, 1'b1, 1'b0};
                end
            end
        endcase
        if (fm && r.fmOk) begin
            r.bitKhz = `BIT_KHZ_125K;
        end
        if (fm && !r.fmOk) begin
            r.valid = 1'b0;
        end
        return r;
    endfunction : rateLookup

    // Fractional divider step: pulse when accumulated rate passes ref clock
    function automatic logic [16:0] accStep(input logic [15:0] acc,
                                            input logic [15:0] khz);
        logic [16:0] sum;
        sum = {1'b0, acc} + {1'b0, khz};
        if (sum >= {1'b0, `REF_CLK_KHZ}) begin
            accStep = {1'b1, 16'(sum - {1'b0, `REF_CLK_KHZ})};
        end else begin
            accStep = {1'b0, sum[15:0]};
        end
    endfunction : accStep

    assign pinRaw = '{ackN: dma_acknowledge_n, mode: modePin,
                      xtal24: crystalIs24, idsel: idselPin,
                      dskChgN: diskChangeN, readyN: driveReadyN};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pinMeta_r <= '1;
            pinSync_r <= '1;
        end else begin
            pinMeta_r <= pinRaw;
            pinSync_r <= pinMeta_r;
        end
    end

    assign coreRun  = digital_output_reg_r[`CTRL0_CORE_RUN_BIT];
    assign altMode  = pinSync_r.mode && pinSync_r.xtal24;
    assign wrData   = regWr && (regAddr == `OFS_DATA);
    assign opcSense = (regWrData & `OPC_MASK) == `OPC_SENSE_INT;
    assign rateInfo = rateLookup(rateSel_r, altMode, coreFmSel);
    assign rateBase = rateLookup(rateSel_r, altMode, 1'b0);
    assign fmRefused = coreFmSel && !rateBase.fmOk;

    // Register file and command decode
    always_comb begin
        digital_output_reg_nxt = digital_output_reg_r;
        ctrl1_nxt    = ctrl1_r;
        rateSel_nxt  = rateSel_r;
        cmdState_nxt = cmdState_r;
        step_nxt     = step_r;
        badCmd_nxt   = badCmd_r;
        rdData_nxt   = 8'h00;
        if (regWr) begin
            unique case (regAddr)
                `OFS_CTRL0:        digital_output_reg_nxt = regWrData;
                `OFS_STATUS_CTRL1: ctrl1_nxt = regWrData;
                `OFS_RATE_DIR:     rateSel_nxt = regWrData[1:0];
                default: ;
            endcase
        end
        if (wrData && coreRun) begin
            unique case (cmdState_r)
                fdc_glue_pkg::CMD_IDLE: begin
                    badCmd_nxt = 1'b0;
                    if ((regWrData & `OPC_MASK) == `OPC_SCAN_EQ ||
                        (regWrData & `OPC_MASK) == `OPC_SCAN_LE ||
                        (regWrData & `OPC_MASK) == `OPC_SCAN_HE) begin
                        badCmd_nxt = 1'b1;
                    end else if ((regWrData & `OPC_MASK) == `OPC_SPECIFY) begin
                        cmdState_nxt = fdc_glue_pkg::CMD_SPEC_STEP;
                    end
                end
                fdc_glue_pkg::CMD_SPEC_STEP: begin
                    step_nxt     = regWrData[7:4];
                    cmdState_nxt = fdc_glue_pkg::CMD_SPEC_HEAD;
                end
                fdc_glue_pkg::CMD_SPEC_HEAD: begin
                    cmdState_nxt = fdc_glue_pkg::CMD_IDLE;
                end
            endcase
        end
        if (!coreRun) begin
            cmdState_nxt = fdc_glue_pkg::CMD_IDLE;
        end
        if (regRd) begin
            unique case (regAddr)
                `OFS_CTRL0:        rdData_nxt = digital_output_reg_r;
                `OFS_STATUS_CTRL1: rdData_nxt = {coreRun, 2'b00,
                    cmdState_r != fdc_glue_pkg::CMD_IDLE, 2'b00,
                    fmRefused, badCmd_r};
                `OFS_DATA:         rdData_nxt = result_r;
                `OFS_RATE_DIR:     rdData_nxt = {!pinSync_r.dskChgN, 7'h00};
                default:           rdData_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            digital_output_reg_r <= `CTRL0_RESET;
            ctrl1_r    <= `CTRL1_RESET;
            rateSel_r  <= `RATE_RESET;
            cmdState_r <= fdc_glue_pkg::CMD_IDLE;
            step_r     <= 4'h0;
            badCmd_r   <= 1'b0;
            rdData_r   <= 8'h00;
        end else begin
            digital_output_reg_r <= digital_output_reg_nxt;
            ctrl1_r    <= ctrl1_nxt;
            rateSel_r  <= rateSel_nxt;
            cmdState_r <= cmdState_nxt;
            step_r     <= step_nxt;
            badCmd_r   <= badCmd_nxt;
            rdData_r   <= rdData_nxt;
        end
    end

    // Clock enables; standby stops both, as the core clock must halt
    always_comb begin
        coreAcc_nxt = 16'h0000;
        bitAcc_nxt  = 16'h0000;
        coreEn_nxt  = 1'b0;
        bitEn_nxt   = 1'b0;
        if (rateInfo.valid && !ctrl1_r[`CTRL1_STANDBY_BIT]) begin
            {coreEn_nxt, coreAcc_nxt} = accStep(coreAcc_r, rateInfo.coreKhz);
            {bitEn_nxt, bitAcc_nxt} = accStep(bitAcc_r, rateInfo.bitKhz);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            coreAcc_r <= 16'h0000;
            bitAcc_r  <= 16'h0000;
            coreEn_r  <= 1'b0;
            bitEn_r   <= 1'b0;
        end else begin
            coreAcc_r <= coreAcc_nxt;
            bitAcc_r  <= bitAcc_nxt;
            coreEn_r  <= coreEn_nxt;
            bitEn_r   <= bitEn_nxt;
        end
    end

    // Ready polling, interrupt causes and DMA request
    always_comb begin
        readyFlag_nxt = readyFlag_r;
        polling_nxt   = polling_r;
        pollDrv_nxt   = pollDrv_r;
        cause_nxt     = cause_r;
        result_nxt    = result_r;
        dmaReq_nxt    = dmaReq_r;
        if (wrData && coreRun && opcSense &&
            cmdState_r == fdc_glue_pkg::CMD_IDLE) begin
            result_nxt = 8'h80;
            for (int i = `NUM_DRIVES - 1; i >= 0; i--) begin
                if (cause_r[i]) begin
                    result_nxt = {`ST0_READY_CHG, 4'h0, 2'(i)};
                end
            end
            // Lowest pending cause answers first
            cause_nxt = cause_r & (cause_r - 4'h1);
        end
        if (polling_r && coreEn_r) begin
            if (!pinSync_r.readyN != readyFlag_r) begin
                cause_nxt[pollDrv_r] = 1'b1;
            end
            pollDrv_nxt = pollDrv_r + 2'h1;
            if (pollDrv_r == 2'(`NUM_DRIVES - 1)) begin
                polling_nxt   = 1'b0;
                readyFlag_nxt = !pinSync_r.readyN;
            end
        end
        if (coreDmaReq && coreRun) begin
            dmaReq_nxt = 1'b1;
        end
        if (!pinSync_r.ackN) begin
            dmaReq_nxt = 1'b0;
        end
        if (!coreRun) begin
            readyFlag_nxt = 1'b0;
            polling_nxt   = 1'b1;
            pollDrv_nxt   = 2'h0;
            cause_nxt     = 4'h0;
            dmaReq_nxt    = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            readyFlag_r <= 1'b0;
            polling_r   <= 1'b1;
            pollDrv_r   <= 2'h0;
            cause_r     <= 4'h0;
            result_r    <= 8'h00;
            dmaReq_r    <= 1'b0;
        end else begin
            readyFlag_r <= readyFlag_nxt;
            polling_r   <= polling_nxt;
            pollDrv_r   <= pollDrv_nxt;
            cause_r     <= cause_nxt;
            result_r    <= result_nxt;
            dmaReq_r    <= dmaReq_nxt;
        end
    end

    crc16_unit crcUnit (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .init     (crcInit),
        .bitValid (coreBitValid && bitEn_r),
        .bitIn    (coreBit),
        .crc      (crcValue)
    );

    assign regRdData  = rdData_r;
    assign coreResetN = coreRun;
    assign coreClkEn  = coreEn_r;
    assign bitRateEn  = bitEn_r;
    assign stepInterval = step_r;
    assign driveReady = readyFlag_r;
    assign standbyOut = ctrl1_r[`CTRL1_STANDBY_BIT];
    assign aux_output_upper = ctrl1_r[`CTRL1_AUX_HI_BIT];
    assign aux_output_lower = ctrl1_r[`CTRL1_AUX_LO_BIT];
    assign request_output_enable = digital_output_reg_r[`CTRL0_REQ_EN_BIT];
    assign dma_request_out = dmaReq_r && request_output_enable;
    assign interrupt_request_out = (|cause_r) && request_output_enable;
    assign dmaRequestOe = request_output_enable || pinSync_r.idsel;
    assign interruptRequestOe = request_output_enable || pinSync_r.idsel;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ack_drops_req_a: assert property (!pinSync_r.ackN |=> !dmaReq_r)
        else $error("DMA request held through bare acknowledge");
    core_rate_8m_a: assert property (rateSel_r == `RATE_CODE_500K
        && !coreFmSel && !ctrl1_r[`CTRL1_STANDBY_BIT] && $stable(rateSel_r)
        |-> rateInfo.coreKhz == `CORE_KHZ_8M
        && rateInfo.bitKhz == `BIT_KHZ_500K)
        else $error("standard setting rate wrong");
    fm_1m_off_a: assert property (rateSel_r == `RATE_CODE_1M
        && !altMode && coreFmSel |=> !bitEn_r)
        else $error("FM bit clock at 1Mbps");
    alt_300k_a: assert property (altMode
        && rateSel_r == `RATE_CODE_ALT && !coreFmSel
        |-> rateInfo.bitKhz == `BIT_KHZ_300K && rateInfo.valid)
        else $error("alternate 300K rate wrong");
    fm_300k_off_a: assert property (altMode
        && rateSel_r == `RATE_CODE_ALT |-> (coreFmSel == fmRefused))
        else $error("FM offered at 300Kbps");
    // Fast core clocks finish a poll pass in eight cycles, so check the start
    poll_four_a: assert property ($rose(coreRun)
        |-> !readyFlag_r && polling_r && cause_r == 4'h0)
        else $error("ready flag not cleared on core start");
    standby_stop_a: assert property (ctrl1_r[`CTRL1_STANDBY_BIT]
        |=> !coreEn_r)
        else $error("core clock runs in standby");
    // Pending causes clear one cycle after the run bit falls
    core_reset_a: assert property (regWr && regAddr == `OFS_CTRL0
        && !regWrData[`CTRL0_CORE_RUN_BIT]
        |=> !coreResetN ##1 cause_r == 4'h0)
        else $error("core not held in reset");
    step_only_a: assert property (wrData && coreRun
        && cmdState_r == fdc_glue_pkg::CMD_SPEC_HEAD |=> $stable(step_r))
        else $error("head time altered step field");
    scan_refused_a: assert property (wrData && coreRun
        && cmdState_r == fdc_glue_pkg::CMD_IDLE
        && (regWrData & `OPC_MASK) == `OPC_SCAN_EQ |=> badCmd_r)
        else $error("scan command accepted");
    aux_mirror_a: assert property ($past(regWr)
        && $past(regAddr) == `OFS_STATUS_CTRL1 |->
        aux_output_upper == $past(regWrData[`CTRL1_AUX_HI_BIT])
        && aux_output_lower == $past(regWrData[`CTRL1_AUX_LO_BIT]))
        else $error("aux pin does not follow register");
    req_disable_a: assert property (!request_output_enable
        |-> !dma_request_out && !interrupt_request_out)
        else $error("request driven while disabled");
    dir_read_a: assert property (regRd && regAddr == `OFS_RATE_DIR
        |=> regRdData[6:0] == 7'h00)
        else $error("input register low bits not zero");

    verify_cycle_c: cover property (dmaReq_r ##1 !pinSync_r.ackN ##1 !dmaReq_r);
    four_causes_c: cover property (cause_r == 4'hF);
    spec_cmd_c: cover property (cmdState_r == fdc_glue_pkg::CMD_SPEC_HEAD);
    alt_rate_c: cover property (altMode && rateSel_r == `RATE_CODE_ALT && coreEn_r);
endmodule : fdc_host_control_glue
`default_nettype wire

// ---- dv/dma_ctrl_model.sv ----
// DMA controller model that answers requests in verify mode
`timescale 1ns/10ps
`default_nettype none
module dma_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic req,
    input  wire logic slow,
    output logic      ackN
);
    int waitCnt = 0;
    initial ackN = 1'b1;
    // verify cycle: acknowledge alone, never a strobe
    always @(posedge ref_clk) begin
        if (req && ackN) begin
            waitCnt <= waitCnt + 1;
            if (!slow || waitCnt >= 5)
                ackN <= 1'b0;
        end else if (!req) begin
            ackN <= 1'b1;
            waitCnt <= 0;
        end
    end
endmodule : dma_ctrl_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the controller host glue
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic modePin = 1'b0, crystalIs24 = 1'b0, idselPin = 1'b0, slow = 1'b0;
    logic diskChangeN = 1'b1, driveReadyN = 1'b0, coreDmaReq = 1'b0;
    logic coreFmSel = 1'b0, coreBit = 1'b0, coreBitValid = 1'b0;
    logic crcInit = 1'b0, dma_acknowledge_n, coreResetN, coreClkEn;
    logic bitRateEn, standbyOut, aux_output_upper, aux_output_lower;
    logic request_output_enable, dma_request_out, dmaRequestOe, driveReady;
    logic interrupt_request_out, interruptRequestOe, meas = 1'b0;
    logic [3:0] stepInterval;
    logic [15:0] crcValue, crcExp = 16'hFFFF;
    int err_total = 0, n_checks = 0, nCore = 0, nBit = 0, cyc = 0;
    // Mode, code, FM, core kHz, bit kHz; zero means enable stopped
    // FM at an unsupported rate invalidates the setting: both enables stop
    int tab[12][5] = '{'{0,0,0,8000,500}, '{0,1,0,0,0}, '{0,2,0,4000,250},
        '{0,3,0,16000,1000}, '{1,0,0,8000,500}, '{1,1,0,4800,300},
        '{1,2,0,4000,250}, '{1,3,0,0,0}, '{0,0,1,8000,125},
        '{0,2,1,4000,125}, '{0,3,1,0,0}, '{1,1,1,0,0}};

    fdc_host_control_glue dut_u (.ref_clk, .rst_n, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .dma_acknowledge_n, .modePin,
        .crystalIs24, .idselPin, .diskChangeN, .driveReadyN, .coreDmaReq,
        .coreFmSel, .coreBit, .coreBitValid, .crcInit, .coreResetN,
        .coreClkEn, .bitRateEn, .standbyOut, .aux_output_upper,
        .aux_output_lower, .request_output_enable, .dma_request_out,
        .dmaRequestOe, .interrupt_request_out, .interruptRequestOe,
        .stepInterval, .driveReady, .crcValue);
    dma_ctrl_model dma_u (.ref_clk, .req(dma_request_out), .slow,
        .ackN(dma_acknowledge_n));

    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (meas) begin
            nCore <= nCore + int'(coreClkEn);
            nBit <= nBit + int'(bitRateEn);
        end
        if (bitRateEn && coreBitValid) begin
            crcExp <= {crcExp[14:0], 1'b0}
                ^ ((crcExp[15] ^ coreBit) ? 16'h1021 : 16'h0000);
            coreBit <= coreBit ^ crcExp[3];
        end
        if (crcInit)
            crcExp <= 16'hFFFF;
        if (cyc == 90000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chkV(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : chkV

    task automatic chkN(input int g, input int e);
        n_checks++;
        if (g < e - 1 || g > e + 1) begin
            err_total++;
            $display("ERROR %0t count %0d exp %0d", $time, g, e);
        end
    endtask : chkN

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chkV(16'(regRdData), 16'(e));
    endtask : rd

    // Enable pulses over 4000 cycles of 25 ns equal kHz / 10
    task automatic rate(input int coreK, input int bitK);
        @(posedge ref_clk);
        nCore <= 0;
        nBit <= 0;
        meas <= 1'b1;
        repeat (4000) @(posedge ref_clk);
        meas <= 1'b0;
        #1;
        chkN(nCore, coreK / 10);
        chkN(nBit, bitK / 10);
    endtask : rate

    // Clock source changes glitch the core, so it is reset afterwards
    task automatic core_reset();
        wr(3'h2, 8'h08);
        wr(3'h2, 8'h0C);
    endtask : core_reset

    task automatic dma_try(input logic s, input int w);
        slow <= s;
        @(posedge ref_clk);
        coreDmaReq <= 1'b1;
        @(posedge ref_clk);
        coreDmaReq <= 1'b0;
        #1;
        chkV(16'(dma_request_out), 16'h0001);
        repeat (w) @(posedge ref_clk);
        #1;
        chkV(16'(dma_request_out), 16'h0000);
    endtask : dma_try

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(3'h2, 8'h00);
        chkV(16'(coreResetN), 16'h0000);
        wr(3'h2, 8'h0C);
        wr(3'h5, 8'h1E);
        rd(3'h2, 8'h0C);
        chkV(16'({coreResetN, request_output_enable}), 16'h0003);
        rate(8000, 500);
        wr(3'h4, 8'h50);
        chkV(16'({aux_output_upper, aux_output_lower}), 16'h0003);
        wr(3'h4, 8'h01);
        chkV(16'({aux_output_upper, standbyOut}), 16'h0001);
        rate(0, 0);
        wr(3'h4, 8'h00);
        foreach (tab[i]) begin
            modePin <= tab[i][0][0];
            crystalIs24 <= tab[i][0][0];
            coreFmSel <= tab[i][2][0];
            wr(3'h7, 8'(tab[i][1]));
            core_reset();
            rate(tab[i][3], tab[i][4]);
            rd(3'h4, (tab[i][2] == 1 && tab[i][4] == 0) ? 8'h82 : 8'h80);
        end
        {modePin, crystalIs24, coreFmSel} <= 3'h0;
        wr(3'h7, 8'h00);
        core_reset();
        repeat (40) @(posedge ref_clk);
        #1;
        chkV(16'(interrupt_request_out), 16'h0001);
        chkV(16'(driveReady), 16'h0001);
        for (int d = 0; d < 5; d++) begin
            wr(3'h5, 8'h08);
            rd(3'h5, (d < 4) ? 8'hC0 | 8'(d) : 8'h80);
        end
        chkV(16'(interrupt_request_out), 16'h0000);
        foreach (tab[i]) begin
            if (i < 3) begin
                wr(3'h5, i == 0 ? 8'h11 : (i == 1 ? 8'h19 : 8'h1D));
                rd(3'h4, 8'h81);
            end
        end
        wr(3'h5, 8'h03);
        rd(3'h4, 8'h90);
        wr(3'h5, 8'hA3);
        wr(3'h5, 8'hFF);
        chkV(16'(stepInterval), 16'h000A);
        rd(3'h4, 8'h80);
        dma_try(1'b0, 8);
        dma_try(1'b1, 16);
        wr(3'h2, 8'h00);
        wr(3'h2, 8'h04);
        coreDmaReq <= 1'b1;
        @(posedge ref_clk);
        coreDmaReq <= 1'b0;
        repeat (40) @(posedge ref_clk);
        #1;
        chkV(16'({dma_request_out, interrupt_request_out}), 16'h0);
        chkV(16'({dmaRequestOe, interruptRequestOe}), 16'h0);
        idselPin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chkV(16'({dmaRequestOe, interruptRequestOe}), 16'h3);
        diskChangeN <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h7, 8'h80);
        crcInit <= 1'b1;
        @(posedge ref_clk);
        crcInit <= 1'b0;
        coreBitValid <= 1'b1;
        repeat (1300) @(posedge ref_clk);
        coreBitValid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chkV(crcValue, crcExp);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
